/* rtl/wdt_pkg.sv */
// Shared constants, types and register map of the watchdog mode control
package wdt_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] WDT_OFS_CTRL   = 8'h00;
	localparam logic [7:0] WDT_OFS_STAT   = 8'h04;
	localparam logic [7:0] WDT_OFS_CLEAR  = 8'h08;
	localparam logic [7:0] WDT_OFS_ENABLE = 8'h0c;

	////////////////////////////////////////////////////////////////////////////
	// Control register bit positions
	localparam int WDT_BIT_FLAG = 7;
	localparam int WDT_BIT_IE   = 6;
	localparam int WDT_BIT_P3   = 5;
	localparam int WDT_BIT_CE   = 4;
	localparam int WDT_BIT_RE   = 3;

	// Event bit positions in status, clear and enable registers
	localparam int WDT_EV_FLAG   = 0;
	localparam int WDT_EV_RESET  = 1;
	localparam int WDT_EV_CE_END = 2;
	localparam int WDT_EV_W      = 3;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and counts
	localparam logic [7:0]          WDT_CTRL_RST  = 8'h00;
	localparam logic [WDT_EV_W-1:0] WDT_EV_RST    = 3'h0;
	localparam logic [2:0]          WDT_CE_CYCLES = 3'h4;

	////////////////////////////////////////////////////////////////////////////
	// Watchdog modes, Gray coded along stopped, interrupt, combined, reset
	typedef enum logic [1:0] {
		WDT_MODE_STOP  = 2'b00,
		WDT_MODE_IRQ   = 2'b01,
		WDT_MODE_BOTH  = 2'b11,
		WDT_MODE_RESET = 2'b10
	} wdt_mode_e;

	// Control register image, bit 7 first
	typedef struct packed {
		logic       flag;
		logic       ie;
		logic       p3;
		logic       ce;
		logic       re;
		logic [2:0] p210;
	} wdt_ctrl_s;

	// Sticky event group
	typedef struct packed {
		logic ce_end;
		logic reset;
		logic flag;
	} wdt_ev_s;

endpackage : wdt_pkg

/* rtl/wdt_mode_dec.sv */
// Mode decoder of the watchdog configuration inputs
`timescale 1ns/100ps
module wdt_mode_dec
	import wdt_pkg::*;
(
	// Configuration
	input  wire logic      clk_mon_i,
	input  wire logic      fuse_i,
	input  wire logic      re_i,
	input  wire logic      ie_i,
	// Decoded mode
	output wdt_mode_e      mode_o
);

	////////////////////////////////////////////////////////////////////////////
	// Priority: all off stops, then monitor or fuse force reset
	always_comb
	begin
		if (!fuse_i && !re_i && !ie_i)
			mode_o = WDT_MODE_STOP;
		else if (clk_mon_i)
			mode_o = WDT_MODE_RESET;
		else if (fuse_i)
			mode_o = WDT_MODE_RESET;
		else if (re_i && ie_i)
			mode_o = WDT_MODE_BOTH;
		else if (ie_i)
			mode_o = WDT_MODE_IRQ;
		else
			mode_o = WDT_MODE_RESET;
	end

endmodule : wdt_mode_dec

/* rtl/wdt_ce_timer.sv */
// Change-enable window timer: holds the bit for a fixed number of cycles
`timescale 1ns/100ps
module wdt_ce_timer
	import wdt_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic start_i,
	// Status
	output logic      ce_o,
	output logic      expired_o
);

	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic       exp_d;

	////////////////////////////////////////////////////////////////////////////
	// A new write restarts the window rather than extending a stale one
	always_comb
	begin
		cnt_d = cnt_q;
		exp_d = 1'b0;
		if (start_i)
			cnt_d = WDT_CE_CYCLES;
		else if (cnt_q != 3'h0)
		begin
			cnt_d = cnt_q - 3'h1;
			exp_d = (cnt_q == 3'h1);
		end
	end

	// Register stage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q     <= 3'h0;
			expired_o <= 1'b0;
		end
		else
		begin
			cnt_q     <= cnt_d;
			expired_o <= exp_d;
		end
	end

	assign ce_o = (cnt_q != 3'h0);

endmodule : wdt_ce_timer

/* rtl/wdt_mode_ctrl.sv */
// Watchdog mode control with a classic Wishbone register slave
`timescale 1ns/100ps
module wdt_mode_ctrl
	import wdt_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Core and timer side
	input  wire logic        gie_i,
	input  wire logic        vec_ack_i,
	input  wire logic        timeout_i,
	input  wire logic        clk_mon_i,
	input  wire logic        fuse_i,
	// Watchdog outputs
	output logic             wdt_irq_o,
	output logic             sys_reset_o,
	output logic      [3:0]  period_o,
	output logic             run_o,
	output logic             irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	// Bus side
	logic                ack_d;
	logic [31:0]         dat_d;
	logic                acc;
	logic                wr;
	logic                wr_ctrl;
	logic                wr_clear;
	logic                wr_enable;
	wdt_ctrl_s           wv;
	wdt_ctrl_s           rd_ctrl;

	// Control register fields
	logic                flag_q;
	logic                flag_d;
	logic                ie_q;
	logic                ie_d;
	logic                re_q;
	logic                re_d;
	logic [3:0]          per_q;
	logic [3:0]          per_d;

	// Change window and decoded mode
	logic                ce;
	logic                ce_end;
	wdt_mode_e           mode;

	// Time-out actions and output next values
	logic                rst_ev;
	logic                flag_ev;
	logic                wirq_d;
	logic                sysrst_d;
	logic                run_d;

	// Event group
	wdt_ev_s             stat_q;
	wdt_ev_s             stat_d;
	logic [WDT_EV_W-1:0] en_q;
	logic [WDT_EV_W-1:0] en_d;
	logic                irq_d;

	////////////////////////////////////////////////////////////////////////////
	// Submodules
	// Mode follows the register fields and the two level inputs at once
	wdt_mode_dec u_dec (
		.clk_mon_i (clk_mon_i),
		.fuse_i    (fuse_i),
		.re_i      (re_q),
		.ie_i      (ie_q),
		.mode_o    (mode)
	);

	// The window starts on any control write with the change bit set
	wdt_ce_timer u_ce (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.start_i   (wr_ctrl && wv.ce),
		.ce_o      (ce),
		.expired_o (ce_end)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode; writes land on the edge that shows ack to the master.
	// Committing on the ack edge keeps a request that the master abandons
	// before its answer from touching any register.
	assign acc       = cyc_i && stb_i;
	assign wr        = acc && we_i && ack_o && sel_i[0];
	assign wr_ctrl   = wr && (adr_i == WDT_OFS_CTRL);
	assign wr_clear  = wr && (adr_i == WDT_OFS_CLEAR);
	assign wr_enable = wr && (adr_i == WDT_OFS_ENABLE);
	assign wv        = wdt_ctrl_s'(dat_i[7:0]);

	// Control register image for reads
	always_comb
	begin
		rd_ctrl      = wdt_ctrl_s'(8'h00);
		rd_ctrl.flag = flag_q;
		rd_ctrl.ie   = ie_q;
		rd_ctrl.p3   = per_q[3];
		rd_ctrl.ce   = ce;
		rd_ctrl.re   = re_q;
		rd_ctrl.p210 = per_q[2:0];
	end

	// Ack one cycle after the strobe, then drop; unmapped reads give zero.
	// Read data is captured together with ack and then held, so a master
	// that samples late still sees the same word.
	always_comb
	begin
		ack_d = acc && !ack_o;
		dat_d = dat_o;
		if (acc && !ack_o)
		begin
			case (adr_i)
				WDT_OFS_CTRL:   dat_d = {24'h000000, rd_ctrl};
				WDT_OFS_STAT:   dat_d = {29'h00000000, stat_q};
				WDT_OFS_ENABLE: dat_d = {29'h00000000, en_q};
				default:        dat_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= ack_d;
			dat_o <= dat_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Time-out actions by mode.
	// Combined mode uses the pending flag as its memory: a time-out that
	// finds the flag still set means the handler never ran.
	always_comb
	begin
		flag_ev = 1'b0;
		rst_ev  = 1'b0;
		if (timeout_i)
		begin
			case (mode)
				WDT_MODE_IRQ:   flag_ev = 1'b1;
				WDT_MODE_BOTH:
				begin
					if (flag_q)
						rst_ev = 1'b1;
					else
						flag_ev = 1'b1;
				end
				WDT_MODE_RESET: rst_ev = 1'b1;
				default:        rst_ev = 1'b0;
			endcase
		end
	end

	// Control fields; a time-out set beats any clear in the same cycle.
	// Vector handling follows the bus write, so a handler that rewrites
	// the enable in that same cycle still loses it in combined mode.
	always_comb
	begin
		flag_d = flag_q;
		ie_d   = ie_q;
		re_d   = re_q;
		per_d  = per_q;
		if (wr_ctrl)
		begin
			ie_d = wv.ie;
			if (wv.flag)
				flag_d = 1'b0;
			// Setting the reset enable is always safe, clearing is not
			if (ce)
			begin
				re_d  = wv.re;
				per_d = {wv.p3, wv.p210};
			end
			else
				re_d = re_q || wv.re;
		end
		if (vec_ack_i)
		begin
			flag_d = 1'b0;
			if (mode == WDT_MODE_BOTH)
				ie_d = 1'b0;
		end
		if (flag_ev)
			flag_d = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			flag_q <= WDT_CTRL_RST[WDT_BIT_FLAG];
			ie_q   <= WDT_CTRL_RST[WDT_BIT_IE];
			re_q   <= WDT_CTRL_RST[WDT_BIT_RE];
			per_q  <= {WDT_CTRL_RST[WDT_BIT_P3], WDT_CTRL_RST[2:0]};
		end
		else
		begin
			flag_q <= flag_d;
			ie_q   <= ie_d;
			re_q   <= re_d;
			per_q  <= per_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs; clock monitoring blocks the interrupt request.
	// Each output is a flop so that no decode glitch reaches core or timer.
	always_comb
	begin
		wirq_d   = gie_i && ie_q && flag_q && !clk_mon_i;
		sysrst_d = rst_ev;
		run_d    = (mode != WDT_MODE_STOP);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wdt_irq_o   <= 1'b0;
			sys_reset_o <= 1'b0;
			period_o    <= {WDT_CTRL_RST[WDT_BIT_P3], WDT_CTRL_RST[2:0]};
			run_o       <= 1'b0;
		end
		else
		begin
			wdt_irq_o   <= wirq_d;
			sys_reset_o <= sysrst_d;
			period_o    <= per_q;
			run_o       <= run_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky events, write-one clear, enable mask; set wins over clear.
	// Status only holds events; the mask is separate so that software
	// can poll the status with the level output kept quiet.
	always_comb
	begin
		stat_d = stat_q;
		en_d   = en_q;
		if (wr_clear)
			stat_d = stat_q & ~wdt_ev_s'(dat_i[WDT_EV_W-1:0]);
		if (wr_enable)
			en_d = dat_i[WDT_EV_W-1:0];
		if (flag_ev)
			stat_d.flag = 1'b1;
		if (rst_ev)
			stat_d.reset = 1'b1;
		if (ce_end)
			stat_d.ce_end = 1'b1;
		irq_d = |(stat_q & en_q);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stat_q <= wdt_ev_s'(WDT_EV_RST);
			en_q   <= WDT_EV_RST;
			irq_o  <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			en_q   <= en_d;
			irq_o  <= irq_d;
		end
	end

endmodule : wdt_mode_ctrl

/* tb/wdt_mode_ctrl_checker.sv */
// Port checker of the watchdog mode control
`timescale 1ns/100ps
module wdt_mode_ctrl_checker
(
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Core events and levels
	input wire logic gie_i,
	input wire logic vec_ack_i,
	input wire logic timeout_i,
	input wire logic clk_mon_i,
	input wire logic fuse_i,
	// Watchdog outputs
	input wire logic wdt_irq_o,
	input wire logic sys_reset_o,
	input wire logic run_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers one cycle after the request, once
	a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack did not follow request");
	a_ack_one_cycle: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	// Request output tied to its causes one cycle earlier
	a_irq_needs_gie: assert property (wdt_irq_o |-> $past(gie_i))
		else $error("irq without global enable");
	a_mon_masks_irq: assert property (wdt_irq_o |-> !$past(clk_mon_i))
		else $error("irq while clock monitor");
	// Vector clears the flag, so the request falls two cycles on
	a_vec_clears_irq: assert property (vec_ack_i && !timeout_i |=> ##1 !wdt_irq_o)
		else $error("irq stayed after vector");
	// Reset only ever comes from a time-out
	a_rst_from_tmo: assert property (sys_reset_o |-> $past(timeout_i))
		else $error("reset without time-out");
	// Always-on fuse forces reset mode
	a_fuse_runs: assert property (fuse_i |=> run_o)
		else $error("fuse did not run watchdog");
	a_fuse_resets: assert property (fuse_i && timeout_i |=> sys_reset_o)
		else $error("fuse time-out without reset");
endmodule : wdt_mode_ctrl_checker

bind wdt_mode_ctrl wdt_mode_ctrl_checker wdt_mode_ctrl_checker_inst (.clk_i, .rst_i, .cyc_i,
	.stb_i, .ack_o, .gie_i, .vec_ack_i, .timeout_i, .clk_mon_i, .fuse_i, .wdt_irq_o,
	.sys_reset_o, .run_o);

/* tb/testbench.sv */
// Self-checking bench of the watchdog mode control
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
	$display("Error %s exp %h got %h", n, e, s); end end
module testbench import wdt_pkg::*;;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic        gie_i, vec_ack_i, timeout_i, clk_mon_i, fuse_i;
	logic        wdt_irq_o, sys_reset_o, run_o, irq_o;
	logic [7:0]  adr_i;
	logic [3:0]  period_o, sel_i, lanes;
	logic [31:0] dat_i, dat_o, rd;
	int          err_count, comparisons;

	// Only lane 0 carries a register; lanes lets a scenario switch it off
	wdt_mode_ctrl wdt_mode_ctrl_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .gie_i, .vec_ack_i, .timeout_i,
		.clk_mon_i, .fuse_i, .wdt_irq_o, .sys_reset_o, .period_o, .run_o, .irq_o);

	// 50 MHz clock
	initial
	begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end

	task give_verdict;
		if (err_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	//////////////////////////////////////////
	// Classic cycle; waits for ack under a bound, never a fixed count
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= lanes;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'h1 && n < 20);
		if (ack_o !== 1'h1)
		begin
			`CHK("ack", 1'h1, ack_o)
			give_verdict();
		end
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
	endtask : wb

	task rc(input logic [7:0] a, input logic [7:0] e, input string nm);
		wb(1'h0, a, 32'h0);
		`CHK(nm, {24'h000000, e}, rd)
	endtask : rc

	// One-cycle vector or time-out pulse; returns once its answer has landed
	task ev(input logic v);
		@(posedge clk_i);
		vec_ack_i <= v;
		timeout_i <= !v;
		@(posedge clk_i);
		vec_ack_i <= 1'h0;
		timeout_i <= 1'h0;
		#1;
	endtask : ev

	task cy(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cy

	//////////////////////////////////////////
	task t_irq_mode;
		rc(WDT_OFS_CTRL, 8'h00, "ctrl");
		@(posedge clk_i);
		gie_i <= 1'h1;
		wb(1'h1, WDT_OFS_CTRL, 32'h40);
		ev(1'h0);
		`CHK("reset", 1'h0, sys_reset_o)
		cy(1);
		`CHK("irq", 1'h1, wdt_irq_o)
		// A time-out with the flag pending still never resets here
		ev(1'h0);
		`CHK("reset", 1'h0, sys_reset_o)
		rc(WDT_OFS_CTRL, 8'hc0, "ctrl");
		wb(1'h1, WDT_OFS_CTRL, 32'h40);
		rc(WDT_OFS_CTRL, 8'hc0, "ctrl");
		wb(1'h1, WDT_OFS_CTRL, 32'hc0);
		rc(WDT_OFS_CTRL, 8'h40, "ctrl");
		ev(1'h0);
		@(posedge clk_i);
		gie_i <= 1'h0;
		cy(2);
		`CHK("irq", 1'h0, wdt_irq_o)
		ev(1'h1);
		rc(WDT_OFS_CTRL, 8'h40, "ctrl");
	endtask : t_irq_mode

	// Sticky status, enable mask, lane select and write-one clear
	task t_events;
		rc(WDT_OFS_STAT, 8'h01, "stat");
		wb(1'h1, WDT_OFS_ENABLE, 32'h1);
		cy(2);
		`CHK("irq_o", 1'h1, irq_o)
		wb(1'h1, WDT_OFS_ENABLE, 32'h0);
		cy(2);
		`CHK("irq_o", 1'h0, irq_o)
		wb(1'h1, WDT_OFS_ENABLE, 32'h1);
		// With lane 0 off the write is answered but lands nowhere
		lanes = 4'h0;
		wb(1'h1, WDT_OFS_ENABLE, 32'h0);
		lanes = 4'hf;
		rc(WDT_OFS_ENABLE, 8'h01, "en");
		wb(1'h1, WDT_OFS_CLEAR, 32'h1);
		cy(2);
		`CHK("irq_o", 1'h0, irq_o)
		wb(1'h1, 8'h10, 32'hff);
		rc(WDT_OFS_STAT, 8'h00, "stat");
		rc(8'h10, 8'h00, "unmapped");
	endtask : t_events

	task t_combined;
		@(posedge clk_i);
		gie_i <= 1'h1;
		wb(1'h1, WDT_OFS_CTRL, 32'h48);
		ev(1'h0);
		`CHK("reset", 1'h0, sys_reset_o)
		cy(1);
		`CHK("irq", 1'h1, wdt_irq_o)
		rc(WDT_OFS_CTRL, 8'hc8, "ctrl");
		ev(1'h1);
		rc(WDT_OFS_CTRL, 8'h08, "ctrl");
		wb(1'h1, WDT_OFS_CTRL, 32'h48);
		ev(1'h0);
		ev(1'h0);
		`CHK("reset", 1'h1, sys_reset_o)
		rc(WDT_OFS_STAT, 8'h03, "stat");
	endtask : t_combined

	// Window opened, read back, missed once, then used in time
	task t_change;
		wb(1'h1, WDT_OFS_CTRL, 32'h88);
		wb(1'h1, WDT_OFS_CTRL, 32'h00);
		rc(WDT_OFS_CTRL, 8'h08, "ctrl");
		ev(1'h0);
		`CHK("reset", 1'h1, sys_reset_o)
		wb(1'h1, WDT_OFS_CTRL, 32'h18);
		rc(WDT_OFS_CTRL, 8'h18, "ctrl");
		wb(1'h1, WDT_OFS_CTRL, 32'h05);
		rc(WDT_OFS_CTRL, 8'h08, "ctrl");
		wb(1'h1, WDT_OFS_CTRL, 32'h18);
		wb(1'h1, WDT_OFS_CTRL, 32'h05);
		rc(WDT_OFS_CTRL, 8'h05, "ctrl");
		`CHK("period", 4'h5, period_o)
		rc(WDT_OFS_STAT, 8'h07, "stat");
	endtask : t_change

	task t_monitor;
		wb(1'h1, WDT_OFS_CTRL, 32'h40);
		ev(1'h0);
		cy(1);
		`CHK("irq", 1'h1, wdt_irq_o)
		@(posedge clk_i);
		clk_mon_i <= 1'h1;
		cy(2);
		`CHK("irq", 1'h0, wdt_irq_o)
		wb(1'h1, WDT_OFS_CTRL, 32'hc0);
		ev(1'h0);
		`CHK("reset", 1'h1, sys_reset_o)
		rc(WDT_OFS_CTRL, 8'h45, "ctrl");
		@(posedge clk_i);
		clk_mon_i <= 1'h0;
		fuse_i    <= 1'h1;
		wb(1'h1, WDT_OFS_CTRL, 32'h00);
		ev(1'h0);
		`CHK("reset", 1'h1, sys_reset_o)
		`CHK("run", 1'h1, run_o)
		@(posedge clk_i);
		fuse_i <= 1'h0;
		cy(2);
		`CHK("run", 1'h0, run_o)
		ev(1'h0);
		`CHK("reset", 1'h0, sys_reset_o)
	endtask : t_monitor

	// Reset in mid-run returns registers and outputs to idle
	task t_reset;
		@(posedge clk_i);
		rst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		`CHK("period", 4'h0, period_o)
		`CHK("irq_o", 1'h0, irq_o)
		rc(WDT_OFS_CTRL, 8'h00, "ctrl");
		rc(WDT_OFS_STAT, 8'h00, "stat");
		rc(WDT_OFS_ENABLE, 8'h00, "en");
	endtask : t_reset

	//////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst_i = 1'h1;
		{cyc_i, stb_i, we_i, gie_i, vec_ack_i, timeout_i, clk_mon_i, fuse_i} = 8'h00;
		adr_i = 8'h00;
		sel_i = 4'h0;
		lanes = 4'hf;
		dat_i = 32'h0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		t_irq_mode();
		t_events();
		t_combined();
		t_change();
		t_monitor();
		t_reset();
		give_verdict();
	end
endmodule : testbench
